//--- csp_regs.vh
// Purpose: constants for the codec serial port block
// Assumes: included by bare name
// Notes: definitions only
`ifndef CSP_REGS_VH
`define CSP_REGS_VH
`define CSP_WORD_W 16
`define CSP_CNT_W 5
`define CSP_LAST_BIT 5'h0f
`define CSP_MCLK_DIV 8'h02
`define CSP_SCLK_DIV 8'h04
`define CSP_DIV_W 16
`define CSP_FIFO_DEPTH 8
`define CSP_FIFO_AW 3
`define CSP_CTRL_FLAG 16'h8000
`define CSP_CTRL_DFLT 16'h0000
`define CSP_ZERO_WORD 16'h0000
`endif

//--- csp_fifo.v
// Purpose: small word FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are exact; flush empties without touching storage
`default_nettype none
module csp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always @(posedge clk_sys) begin
    if (srst || flush) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // csp_fifo
`default_nettype wire

//--- csp_codec_port.v
// Purpose: codec serial port with enable gating, bit clock divider and word framing
// Assumes: clk_sys stands for the codec master clock; all pins sampled synchronously
// Notes: received sample words go through an 8-word FIFO; transmit words wait in a register
// What this block does
// - Receive frame sync is sampled on the falling bit-clock edge.
// - Each receive data bit is captured on the falling bit-clock edge.
// - Received words are sorted into control words and sample data words.
// - With the gate low, receive data and frame sync are ignored.
// - The asynchronous gate input is synchronised before use.
// - With the gate low, all port outputs are high impedance.
// - With the gate low, the bit clock is stopped.
// - Control and data registers keep their contents across a gate-low period.
// - On gate return, the divider and the rx/tx framing counters and states restart from reset values; the FIFO and tx holding register keep theirs.
// - Frame syncs are one bit wide; tx sync leads the MSB, from rising edge.
// - Output bits launch on the rising edge; data line floats when idle.
// - Bit clock equals master clock over both dividers' product.
// - Active-low codec reset clears control registers and the whole port.
`include "csp_regs.vh"
`default_nettype none
module csp_codec_port (
  // Clock and resets
  input wire clk_sys,
  input wire srst,
  input wire codec_reset_n,
  // Port gate from the processor
  input wire port_gate_in,
  // Serial pins
  output wire codec_bit_clock_pin,
  output wire codec_bit_clock_oe,
  input wire rx_frame_sync,
  input wire serial_rx_line,
  output wire serial_tx_line,
  output wire serial_tx_oe,
  output wire tx_frame_sync,
  output wire tx_frame_sync_oe,
  // Received sample words
  output wire rx_data_valid,
  input wire rx_data_ready,
  output wire [`CSP_WORD_W-1:0] rx_data,
  // Received control word
  output reg [`CSP_WORD_W-1:0] ctrl_word_q,
  output reg ctrl_strobe_q,
  // Words to send
  input wire tx_valid,
  output wire tx_ready,
  input wire [`CSP_WORD_W-1:0] tx_word
);
  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam [`CSP_DIV_W-1:0] HALF_DIV = (`CSP_MCLK_DIV * `CSP_SCLK_DIV) / 2;

  function [`CSP_CNT_W-1:0] bump;
    input [`CSP_CNT_W-1:0] v;
    begin
      bump = v + 1'b1;
    end
  endfunction

  wire clr;
  reg gate_s1_q;
  reg gate_s2_q;
  reg gate_prev_q;
  wire gate_on;
  wire restart;
  reg [`CSP_DIV_W-1:0] div_q;
  reg sclk_q;
  wire sclk_rise;
  wire sclk_fall;
  reg [1:0] rx_st_q;
  reg [`CSP_CNT_W-1:0] rx_cnt_q;
  reg [`CSP_WORD_W-1:0] rx_sh_q;
  reg rx_push_q;
  reg [`CSP_WORD_W-1:0] rx_word_q;
  wire fifo_in_ready;
  reg [1:0] tx_st_q;
  reg [`CSP_CNT_W-1:0] tx_cnt_q;
  reg [`CSP_WORD_W-1:0] tx_hold_q;
  reg tx_full_q;
  reg [`CSP_WORD_W-1:0] tx_sh_q;
  reg tx_fs_q;
  reg tx_bit_q;
  reg tx_drive_q;

  // Codec reset pin and system reset both clear everything
  assign clr = srst | ~codec_reset_n;

  // Gate synchroniser; first stage feeds only the second
  always @(posedge clk_sys) begin
    if (clr) begin
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      gate_s1_q <= port_gate_in;
      gate_s2_q <= gate_s1_q;
      gate_prev_q <= gate_s2_q;
    end
  end
  assign gate_on = gate_s2_q;
  assign restart = gate_s2_q & ~gate_prev_q;

  // Bit clock divider, held still while gated off
  always @(posedge clk_sys) begin
    if (clr || !gate_on || restart) begin
      div_q <= {`CSP_DIV_W{1'b0}};
      sclk_q <= 1'b0;
    end else if (div_q == HALF_DIV - 1'b1) begin
      div_q <= {`CSP_DIV_W{1'b0}};
      sclk_q <= ~sclk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign sclk_rise = gate_on & ~restart & (div_q == HALF_DIV - 1'b1) & ~sclk_q;
  assign sclk_fall = gate_on & ~restart & (div_q == HALF_DIV - 1'b1) & sclk_q;

  // Outputs float while gated off
  assign codec_bit_clock_pin = sclk_q;
  assign codec_bit_clock_oe = gate_on;
  assign tx_frame_sync = tx_fs_q;
  assign tx_frame_sync_oe = gate_on;
  assign serial_tx_line = tx_bit_q;
  assign serial_tx_oe = gate_on & tx_drive_q;

  // Receive framing on falling edges
  always @(posedge clk_sys) begin
    if (clr || !gate_on || restart) begin
      rx_st_q <= ST_IDLE;
      rx_cnt_q <= {`CSP_CNT_W{1'b0}};
      rx_sh_q <= `CSP_ZERO_WORD;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      if (sclk_fall) begin
        case (rx_st_q)
          ST_IDLE: begin
            if (rx_frame_sync) begin
              rx_st_q <= ST_SHIFT;
              rx_cnt_q <= {`CSP_CNT_W{1'b0}};
            end
          end
          ST_SHIFT: begin
            rx_sh_q <= {rx_sh_q[`CSP_WORD_W-2:0], serial_rx_line};
            rx_cnt_q <= bump(rx_cnt_q);
            if (rx_cnt_q == `CSP_LAST_BIT) begin
              rx_push_q <= 1'b1;
              rx_st_q <= rx_frame_sync ? ST_SHIFT : ST_IDLE;
              rx_cnt_q <= {`CSP_CNT_W{1'b0}};
            end
          end
          default: begin
            rx_st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Sorting of words; the control register survives gate-off
  always @(posedge clk_sys) begin
    if (clr) begin
      ctrl_word_q <= `CSP_CTRL_DFLT;
      ctrl_strobe_q <= 1'b0;
      rx_word_q <= `CSP_ZERO_WORD;
    end else begin
      ctrl_strobe_q <= 1'b0;
      if (rx_push_q) begin
        if ((rx_sh_q & `CSP_CTRL_FLAG) != `CSP_ZERO_WORD) begin
          ctrl_word_q <= rx_sh_q;
          ctrl_strobe_q <= 1'b1;
        end else begin
          rx_word_q <= rx_sh_q;
        end
      end
    end
  end

  // Sample words queue up; a full queue drops the newest word
  csp_fifo #(
    .WIDTH(`CSP_WORD_W),
    .DEPTH(`CSP_FIFO_DEPTH),
    .AW(`CSP_FIFO_AW)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .srst(clr),
    .flush(1'b0),
    .in_valid(rx_push_q & ((rx_sh_q & `CSP_CTRL_FLAG) == `CSP_ZERO_WORD)),
    .in_ready(fifo_in_ready),
    .in_data(rx_sh_q),
    .out_valid(rx_data_valid),
    .out_ready(rx_data_ready),
    .out_data(rx_data)
  );

  // Transmit holding register keeps its word across gate-off
  assign tx_ready = ~tx_full_q;
  always @(posedge clk_sys) begin
    if (clr) begin
      tx_hold_q <= `CSP_ZERO_WORD;
      tx_full_q <= 1'b0;
    end else begin
      if (tx_valid && !tx_full_q) begin
        tx_hold_q <= tx_word;
        tx_full_q <= 1'b1;
      end else if (tx_st_q == ST_IDLE && sclk_rise && tx_full_q) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // Transmit framing on rising edges: sync leads the MSB by one period
  always @(posedge clk_sys) begin
    if (clr || !gate_on || restart) begin
      tx_st_q <= ST_IDLE;
      tx_cnt_q <= {`CSP_CNT_W{1'b0}};
      tx_sh_q <= `CSP_ZERO_WORD;
      tx_fs_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_drive_q <= 1'b0;
    end else if (sclk_rise) begin
      case (tx_st_q)
        ST_IDLE: begin
          tx_drive_q <= 1'b0;
          tx_fs_q <= tx_full_q;
          if (tx_full_q) begin
            tx_sh_q <= tx_hold_q;
            tx_st_q <= ST_SHIFT;
            tx_cnt_q <= {`CSP_CNT_W{1'b0}};
          end
        end
        ST_SHIFT: begin
          tx_fs_q <= 1'b0;
          tx_drive_q <= 1'b1;
          tx_bit_q <= tx_sh_q[`CSP_WORD_W-1];
          tx_sh_q <= {tx_sh_q[`CSP_WORD_W-2:0], 1'b0};
          tx_cnt_q <= bump(tx_cnt_q);
          if (tx_cnt_q == `CSP_LAST_BIT) begin
            tx_st_q <= ST_IDLE;
          end
        end
        default: begin
          tx_st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // csp_codec_port
`default_nettype wire

//--- csp_codec_port_asserts.sv
// Purpose: pin and stream assertions for csp_codec_port
// Assumes: bound to the design top
// Notes: gate-timed checks drop out while the gate is low
`default_nettype none
module csp_codec_port_asserts (
  // Clock, resets and gate
  input wire logic clk_sys, srst, codec_reset_n, port_gate_in,
  // Serial pins
  input wire logic codec_bit_clock_pin, codec_bit_clock_oe,
  input wire logic serial_tx_oe, tx_frame_sync, tx_frame_sync_oe,
  // Streams
  input wire logic rx_data_valid, rx_data_ready, ctrl_strobe_q,
  input wire logic [15:0] ctrl_word_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst || !codec_reset_n);
  chk_gate_sync: assert property ($rose(port_gate_in) && !codec_bit_clock_oe |=>
    !codec_bit_clock_oe ##[1:2] codec_bit_clock_oe) else $error("gate sync delay wrong");
  chk_gate_float: assert property (!port_gate_in [*4] |->
    !(codec_bit_clock_oe || serial_tx_oe || tx_frame_sync_oe)) else $error("pins not floated");
  chk_clock_stop: assert property (!port_gate_in [*5] |-> !codec_bit_clock_pin)
    else $error("bit clock runs while gated");
  chk_sclk_period: assert property (disable iff (srst || !codec_reset_n || !port_gate_in)
    $rose(codec_bit_clock_pin) |-> codec_bit_clock_pin [*4] ##1 !codec_bit_clock_pin [*4]
    ##1 codec_bit_clock_pin) else $error("bit clock period wrong");
  chk_txfs_width: assert property (disable iff (srst || !codec_reset_n || !port_gate_in)
    $rose(tx_frame_sync) |-> tx_frame_sync [*8] ##1 (!tx_frame_sync && serial_tx_oe))
    else $error("tx frame sync wrong");
  chk_tx_bits: assert property (disable iff (srst || !codec_reset_n || !port_gate_in)
    $rose(serial_tx_oe) |-> ##127 serial_tx_oe ##1 !serial_tx_oe) else $error("tx length wrong");
  chk_ctrl_strobe: assert property (ctrl_strobe_q |-> ctrl_word_q[15] ##1 !ctrl_strobe_q)
    else $error("control strobe wrong");
  chk_ctrl_keep: assert property (!codec_bit_clock_oe && !$past(codec_bit_clock_oe) &&
    !$past(codec_bit_clock_oe, 2) |->
    $stable(ctrl_word_q)) else $error("control word changed while gated");
  cov_tx_word: cover property ($fell(serial_tx_oe));
  cov_ctrl: cover property (ctrl_strobe_q);
  cov_rx_stall: cover property (rx_data_valid && !rx_data_ready);
endmodule // csp_codec_port_asserts
bind csp_codec_port csp_codec_port_asserts i_chk (.*);
`default_nettype wire

//--- csp_dsp_model.sv
// Purpose: processor-side serial port model
// Assumes: moves its pins one clk_sys after each bit clock rise
// Notes: aborts when the clock is gated; a released line shows the inverse bit
`default_nettype none
module csp_dsp_model (
  // Clocks
  input wire logic clk_sys, sclk, sclk_oe,
  // Request
  input wire logic go,
  input wire logic [15:0] word,
  output logic busy,
  // Pins
  output logic fs, dat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q = 0;
  logic [15:0] sh = 0;
  logic [4:0] n = 0;
  initial {busy, fs, dat} = 3'b000;
  always @(posedge clk_sys) begin
    sclk_q <= sclk;
    if (!sclk_oe) begin
      busy <= 1'b0;
      fs <= 1'b0;
      n <= 5'h00;
    end else if (sclk && !sclk_q) begin
      if (!busy && go) begin
        busy <= 1'b1;
        fs <= 1'b1;
        sh <= word;
        n <= 5'h10;
      end else if (n != 5'h00) begin
        fs <= 1'b0;
        dat <= sh[15];
        sh <= {sh[14:0], 1'b0};
        n <= n - 5'h01;
      end else if (busy) begin
        busy <= 1'b0;
        dat <= ~dat;
      end
    end
  end
endmodule // csp_dsp_model
`default_nettype wire

//--- csp_codec_port_bench.sv
// Purpose: self-checking bench for csp_codec_port
// Assumes: partner model drives the receive pins
// Notes: random words come from an LFSR
`include "csp_regs.vh"
`default_nettype none
module csp_codec_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, srst = 1, codec_reset_n = 1, port_gate_in = 1, rx_data_ready = 0;
  logic tx_valid = 0, go = 0, pin_q = 0, busy, codec_bit_clock_pin, codec_bit_clock_oe;
  logic rx_frame_sync, serial_rx_line, serial_tx_line, serial_tx_oe, tx_frame_sync;
  logic tx_frame_sync_oe, rx_data_valid, ctrl_strobe_q, tx_ready;
  logic [15:0] tx_word = 0, wd = 0, rx_data, ctrl_word_q, exp_ctrl = 0, tsh = 0;
  logic [31:0] seed = 32'ha0c2;
  logic [15:0] rxq[$], txq[$];
  int miscompares = 0, n_checks = 0, cyc = 0, tn = 0;
  initial forever #20 clk_sys = ~clk_sys;
  csp_codec_port i_dut (.*);
  csp_dsp_model i_dsp (.clk_sys(clk_sys), .sclk(codec_bit_clock_pin),
    .sclk_oe(codec_bit_clock_oe), .go(go), .word(wd), .busy(busy), .fs(rx_frame_sync),
    .dat(serial_rx_line));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Words with the control flag only update the expected control word
  task automatic start(input logic [15:0] w);
    go <= 1'b1;
    wd <= w;
    do @(negedge clk_sys); while (busy !== 1'b1);
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic send(input logic [15:0] w);
    if ((w & `CSP_CTRL_FLAG) != 16'h0000) exp_ctrl = w;
    else if (rxq.size() < `CSP_FIFO_DEPTH) rxq.push_back(w);
    start(w);
    do @(negedge clk_sys); while (busy === 1'b1);
    @(posedge clk_sys);
  endtask
  task automatic tx(input logic [15:0] w);
    tx_valid <= 1'b1;
    tx_word <= w;
    do @(negedge clk_sys); while (tx_ready !== 1'b1);
    @(posedge clk_sys);
    txq.push_back(w);
    tx_valid <= 1'b0;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      test_done();
    end
    pin_q <= codec_bit_clock_pin;
    if ((rx_data_valid & rx_data_ready) === 1'b1)
      chk(rx_data, rxq.size() ? rxq.pop_front() : 16'hffff);
    if (ctrl_strobe_q === 1'b1) chk(ctrl_word_q, exp_ctrl);
    if ({pin_q, codec_bit_clock_pin, serial_tx_oe} === 3'b101) begin
      tsh = {tsh[14:0], serial_tx_line};
      tn++;
      if (tn == 16) begin
        tn = 0;
        chk(tsh, txq.size() ? txq.pop_front() : ~tsh);
      end
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      rx_data_ready <= seed[3] | seed[4];
      send(seed[15:0]);
      tx(seed[31:16]);
    end
    send(`CSP_CTRL_FLAG);
    send(16'hffff);
    send(16'h7fff);
    chk(ctrl_word_q, 16'hffff);
    rx_data_ready <= 1'b0;
    for (int i = 0; i < 9; i++) send(16'h0100 + 16'(i));
    start(16'h0abc);
    repeat (60) @(posedge clk_sys);
    port_gate_in <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk(ctrl_word_q, 16'hffff);
    port_gate_in <= 1'b1;
    repeat (48) @(posedge clk_sys);
    rx_data_ready <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk(16'(rxq.size()), 16'h0000);
    send(16'h1234);
    repeat (4) @(posedge clk_sys);
    chk(16'(rxq.size()), 16'h0000);
    rx_data_ready <= 1'b0;
    send(16'h0055);
    codec_reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    codec_reset_n <= 1'b1;
    rxq.delete();
    @(negedge clk_sys);
    chk(ctrl_word_q, `CSP_CTRL_DFLT);
    chk({15'h0000, rx_data_valid}, 16'h0000);
    rx_data_ready <= 1'b1;
    repeat (200) @(posedge clk_sys);
    chk(16'(txq.size()), 16'h0000);
    test_done();
  end
endmodule // csp_codec_port_bench
`default_nettype wire
